/* File: verilog/microprogram_debug_console.v */
/*
  Microprogram debug console: instruction override, step/run sequencing,
  address compare halt, control and data store parity traps, APB registers.
  Assumes the processor advances one microcycle on each clock where
  cpu_run is high and holds all state otherwise.
*/
//
// Contract
// - switch word replaces control store when selected
// - override applied after instruction latches
// - switch up gives one, down zero
// - 5C word maps bits to address lines
// - step mode runs one cycle per press
// - run mode press starts continuous cycling
// - selector picks data or control address
// - compare target taken from address switches
// - compare enabled halts on address match
// - step resumes; halts only on next access
// - parity valid: one group or all three
// - control store parity error traps 8000
// - data store parity error traps 8002
`timescale 1ns/1ns
`include "debug_console_defines.vh"
module microprogram_debug_console (
  // clock and reset
  input wire clk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // processor side
  input wire [23:0] cs_instr_in,
  input wire [15:0] cs_addr_in,
  input wire [15:0] ds_addr_in,
  input wire [7:0] acc_in,
  input wire read_load,
  input wire [8:0] read_data_high_byte,
  input wire [8:0] read_data_low_byte,
  output wire cpu_run,
  output wire [23:0] instr_out,
  output wire trap_req,
  output wire [15:0] trap_addr,
  // operator indicators
  output wire [23:0] ind_instr,
  output wire [15:0] ind_addr,
  output wire [7:0] ind_acc
);
  reg instr_src_ff;
  reg addr_src_ff;
  reg cmp_en_ff;
  reg run_mode_ff;
  reg [23:0] sw_instr_ff;
  reg [15:0] cmp_addr_ff;
  reg [23:0] latch_ff;
  reg [23:0] instr_out_ff;
  reg [1:0] seq_ff;
  reg [1:0] nxt_seq;
  reg skip_ff;
  reg cmp_halt_ff;
  reg cs_perr_ff;
  reg ds_perr_ff;
  reg trap_req_ff;
  reg [15:0] trap_addr_ff;
  reg ran_ff;
  reg [23:0] ind_instr_ff;
  reg [15:0] ind_addr_ff;
  reg [7:0] ind_acc_ff;

  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire step_press;
  wire stop_press;
  wire [15:0] mon_addr;
  wire hit;
  wire cs_err;
  wire ds_err;

  // maps a 5C-pattern word onto the sixteen address lines
  function [15:0] branch_map;
    input [23:0] w;
    begin
      branch_map = {w[7:2], w[17:8]};
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_CTRL) || (a == `OFS_SW_INSTR) || (a == `OFS_CMP_ADDR) ||
                  (a == `OFS_STATUS) || (a == `OFS_VIEW_INSTR) || (a == `OFS_VIEW_ADDR);
    end
  endfunction

  // zero wait states: read data is prepared during the setup phase
  assign pready = 1'b1;
  assign addr_ok = is_mapped(paddr);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign step_press = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_STEP];
  assign stop_press = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_STOP];

  // operator switch registers
  always @(posedge clk) begin
    if (srst) begin
      instr_src_ff <= 1'b0;
      addr_src_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
      run_mode_ff <= 1'b1;
      sw_instr_ff <= 24'h000000;
      cmp_addr_ff <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL: begin
          instr_src_ff <= pwdata[`CTRL_INSTR_SRC];
          addr_src_ff <= pwdata[`CTRL_ADDR_SRC];
          cmp_en_ff <= pwdata[`CTRL_CMP_EN];
          run_mode_ff <= pwdata[`CTRL_RUN_MODE];
        end
        `OFS_SW_INSTR: sw_instr_ff <= pwdata[23:0];
        `OFS_CMP_ADDR: cmp_addr_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `OFS_CTRL: prdata <= {28'h0000000, run_mode_ff, cmp_en_ff, addr_src_ff, instr_src_ff};
        `OFS_SW_INSTR: prdata <= {8'h00, sw_instr_ff};
        `OFS_CMP_ADDR: prdata <= {16'h0000, cmp_addr_ff};
        `OFS_STATUS: prdata <= {28'h0000000, (seq_ff == `SEQ_RUN), cmp_halt_ff,
                                ds_perr_ff, cs_perr_ff};
        `OFS_VIEW_INSTR: prdata <= {8'h00, ind_instr_ff};
        `OFS_VIEW_ADDR: prdata <= {8'h00, ind_acc_ff, ind_addr_ff};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // monitored address follows the source selector
  assign mon_addr = addr_src_ff ? cs_addr_in : ds_addr_in;
  // the first cycle after a resume is skipped so the same access cannot re-halt
  assign hit = cmp_en_ff && !skip_ff && (mon_addr == cmp_addr_ff);
  // processor only advances when allowed; otherwise its state is frozen
  assign cpu_run = ((seq_ff == `SEQ_RUN) && !hit) || (seq_ff == `SEQ_STEP);

  always @* begin
    nxt_seq = seq_ff;
    case (seq_ff)
      `SEQ_HOLD: begin
        if (step_press) begin
          // the press rewrites the mode bit, so the mode written with it decides
          nxt_seq = pwdata[`CTRL_RUN_MODE] ? `SEQ_RUN : `SEQ_STEP;
        end
      end
      `SEQ_STEP: nxt_seq = `SEQ_HOLD;
      `SEQ_RUN: begin
        if (hit || stop_press || !run_mode_ff) begin
          nxt_seq = `SEQ_HOLD;
        end
      end
      default: nxt_seq = `SEQ_HOLD;
    endcase
  end

  // after reset the console waits for a step press before releasing the cpu
  always @(posedge clk) begin
    if (srst) begin
      seq_ff <= `SEQ_HOLD;
      skip_ff <= 1'b0;
      cmp_halt_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      if (seq_ff == `SEQ_HOLD && step_press) begin
        skip_ff <= 1'b1;
        cmp_halt_ff <= 1'b0;
      end else if (cpu_run) begin
        skip_ff <= 1'b0;
      end
      if (seq_ff == `SEQ_RUN && hit) begin
        cmp_halt_ff <= 1'b1;
      end
    end
  end

  // instruction latch, then the switch word substitutes behind it
  always @(posedge clk) begin
    if (srst) begin
      latch_ff <= 24'h000000;
      instr_out_ff <= 24'h000000;
    end else begin
      if (cpu_run) begin
        latch_ff <= cs_instr_in;
      end
      instr_out_ff <= instr_src_ff ? sw_instr_ff : latch_ff;
    end
  end
  assign instr_out = instr_out_ff;

  cs_parity_check u_parity (
    .instr_word(instr_out_ff),
    .read_data_high_byte(read_data_high_byte),
    .read_data_low_byte(read_data_low_byte),
    .control_store_parity_error(cs_err),
    .data_store_parity_error(ds_err)
  );

  // traps are raised only on executed cycles; control store error has priority
  always @(posedge clk) begin
    if (srst) begin
      trap_req_ff <= 1'b0;
      trap_addr_ff <= 16'h0000;
      cs_perr_ff <= 1'b0;
      ds_perr_ff <= 1'b0;
    end else begin
      trap_req_ff <= 1'b0;
      if (cpu_run && cs_err) begin
        trap_req_ff <= 1'b1;
        trap_addr_ff <= `TRAP_CS_PERR;
      end else if (cpu_run && read_load && ds_err) begin
        trap_req_ff <= 1'b1;
        trap_addr_ff <= `TRAP_DS_PERR;
      end
      // sticky flags: a new error wins over a clear in the same cycle
      if (cpu_run && cs_err) begin
        cs_perr_ff <= 1'b1;
      end else if (wr_en && paddr == `OFS_STATUS && pwdata[`ST_CS_PERR]) begin
        cs_perr_ff <= 1'b0;
      end
      if (cpu_run && read_load && ds_err) begin
        ds_perr_ff <= 1'b1;
      end else if (wr_en && paddr == `OFS_STATUS && pwdata[`ST_DS_PERR]) begin
        ds_perr_ff <= 1'b0;
      end
    end
  end
  assign trap_req = trap_req_ff;
  assign trap_addr = trap_addr_ff;

  // indicators follow the cycle just executed and stay frozen while held, except while the switch word is selected
  always @(posedge clk) begin
    if (srst) begin
      ran_ff <= 1'b0;
      ind_instr_ff <= 24'h000000;
      ind_addr_ff <= 16'h0000;
      ind_acc_ff <= 8'h00;
    end else begin
      ran_ff <= cpu_run;
      ind_instr_ff <= instr_out_ff;
      if (ran_ff || instr_src_ff) begin
        if (instr_src_ff && instr_out_ff[`BRANCH_MSB:`BRANCH_LSB] == `BRANCH_OP) begin
          ind_addr_ff <= branch_map(instr_out_ff);
        end else begin
          ind_addr_ff <= mon_addr;
        end
        ind_acc_ff <= acc_in;
      end
    end
  end
  assign ind_instr = ind_instr_ff;
  assign ind_addr = ind_addr_ff;
  assign ind_acc = ind_acc_ff;
endmodule // microprogram_debug_console

/* File: include/debug_console_defines.vh */
/*
  Constants for the microprogram debug console: register offsets, field
  positions, trap vectors and sequencing codes.
  Assumes inclusion by bare name from files under verilog/.
*/
`ifndef DEBUG_CONSOLE_DEFINES_VH
`define DEBUG_CONSOLE_DEFINES_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SW_INSTR 8'h04
`define OFS_CMP_ADDR 8'h08
`define OFS_STATUS 8'h0C
`define OFS_VIEW_INSTR 8'h10
`define OFS_VIEW_ADDR 8'h14

// control register fields
`define CTRL_INSTR_SRC 0
`define CTRL_ADDR_SRC 1
`define CTRL_CMP_EN 2
`define CTRL_RUN_MODE 3
`define CTRL_STEP 8
`define CTRL_STOP 9

// status register fields
`define ST_CS_PERR 0
`define ST_DS_PERR 1
`define ST_CMP_HALT 2
`define ST_RUNNING 3

// view register field positions
`define VIEW_ACC_LSB 16
`define VIEW_ACC_MSB 23

// manual word pattern that routes instruction bits to address lines
// only the upper six bits of the 5C pattern are decoded, so bits 17:16 stay address bits
`define BRANCH_OP 6'h17
`define BRANCH_LSB 18
`define BRANCH_MSB 23

// hardware trap vectors
`define TRAP_CS_PERR 16'h8000
`define TRAP_DS_PERR 16'h8002

// sequencer states
`define SEQ_HOLD 2'h0
`define SEQ_STEP 2'h1
`define SEQ_RUN 2'h2

`endif

/* File: verilog/cs_parity_check.v */
/*
  Parity checks for the debug console: three odd-parity groups of the
  issued control store word, and odd parity of the two read data bytes.
  Assumes each 9-bit read byte carries its parity in bit 8.
*/
`timescale 1ns/1ns
module cs_parity_check (
  // control store word as issued
  input wire [23:0] instr_word,
  // read data bytes with parity
  input wire [8:0] read_data_high_byte,
  input wire [8:0] read_data_low_byte,
  // results
  output wire control_store_parity_error,
  output wire data_store_parity_error
);
  wire [2:0] odd_grp;

  assign odd_grp[0] = ^instr_word[7:0];
  assign odd_grp[1] = ^instr_word[15:8];
  assign odd_grp[2] = ^instr_word[23:16];

  // one group high or all three high is valid
  assign control_store_parity_error = !((odd_grp == 3'h1) || (odd_grp == 3'h2) ||
                                        (odd_grp == 3'h4) || (odd_grp == 3'h7));

  assign data_store_parity_error = !(^read_data_high_byte) || !(^read_data_low_byte);
endmodule // cs_parity_check

/* File: test/debug_console_sva.sv */
/* checker for the debug console top; bound below.
   assumes the register map and step timing of the console. */
`timescale 1ns/1ns
module debug_console_sva (
  // clock, reset and apb requests
  input wire clk, srst, psel, penable, pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  // processor side
  input wire read_load, cpu_run, trap_req,
  input wire [15:0] cs_addr_in, ds_addr_in, trap_addr, ind_addr,
  input wire [23:0] instr_out,
  input wire [8:0] read_data_high_byte, read_data_low_byte
);
  reg [23:0] sw_ff;
  reg [15:0] cmp_ff;
  reg [3:0] ctl_ff;
  wire wr = psel && penable && pwrite;
  wire step_wr = wr && paddr == 8'h00 && pwdata[8] && !pwdata[9];
  // odd total means one or all three groups odd
  wire cs_err = ~^instr_out;
  wire ds_err = read_load && !(^read_data_high_byte && ^read_data_low_byte);
  wire cause = cpu_run && (cs_err || ds_err);
  wire [15:0] sel = ctl_ff[1] ? cs_addr_in : ds_addr_in;
  always @(posedge clk) begin
    if (srst) begin
      sw_ff <= 24'h000000;
      cmp_ff <= 16'h0000;
      ctl_ff <= 4'h8;
    end else if (wr) begin
      if (paddr == 8'h00) ctl_ff <= pwdata[3:0];
      if (paddr == 8'h04) sw_ff <= pwdata[23:0];
      if (paddr == 8'h08) cmp_ff <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_cs_trap; cpu_run && cs_err |=> trap_req && trap_addr == 16'h8000; endproperty
  a_cs_trap: assert property (p_cs_trap) else $error("store trap missing");
  property p_ds_trap; cpu_run && ds_err && !cs_err |=> trap_req && trap_addr == 16'h8002; endproperty
  a_ds_trap: assert property (p_ds_trap) else $error("read trap missing");
  property p_no_false; trap_req |-> $past(cause); endproperty
  a_no_false: assert property (p_no_false) else $error("trap without fault");
  property p_override; ctl_ff[0] |=> instr_out == $past(sw_ff); endproperty
  a_override: assert property (p_override) else $error("switch word not issued");
  property p_freeze;
    !cpu_run && !$past(cpu_run) && !ctl_ff[0] && !$past(ctl_ff[0])
      |=> $stable(instr_out) && $stable(ind_addr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("held state moved");
  property p_step; step_wr && !pwdata[3] && !cpu_run |=> cpu_run ##1 !cpu_run; endproperty
  a_step: assert property (p_step) else $error("step not one cycle");
  property p_run; step_wr && pwdata[3] && !pwdata[2] && !cpu_run |=> cpu_run [*4]; endproperty
  a_run: assert property (p_run) else $error("run not continuous");
  property p_resume; step_wr && !cpu_run |=> cpu_run; endproperty
  a_resume: assert property (p_resume) else $error("press did not resume");
  property p_cmp; ctl_ff[2] && $past(cpu_run) && sel == cmp_ff |-> !cpu_run; endproperty
  a_cmp: assert property (p_cmp) else $error("no halt on match");
endmodule // debug_console_sva
bind microprogram_debug_console debug_console_sva i_sva (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .read_load(read_load),
  .cpu_run(cpu_run), .trap_req(trap_req), .cs_addr_in(cs_addr_in), .ds_addr_in(ds_addr_in),
  .trap_addr(trap_addr), .ind_addr(ind_addr), .instr_out(instr_out),
  .read_data_high_byte(read_data_high_byte), .read_data_low_byte(read_data_low_byte));

/* File: test/cpu_model.sv */
/* behavioural sequencer and control store; advances one address on each rising clock edge where cpu_run is high.
   assumes the console holds it by cpu_run alone. */
`timescale 1ns/1ns
module cpu_model (
  input wire clk, srst, cpu_run, bad_ds,
  output reg [15:0] cs_addr_in,
  output reg [7:0] acc_in,
  output wire [15:0] ds_addr_in,
  output wire [23:0] cs_instr_in,
  output wire read_load,
  output wire [8:0] read_data_high_byte, read_data_low_byte
);
  wire [22:0] body = {cs_addr_in, 7'h2D};
  // store words always leave with a valid group pattern
  assign cs_instr_in = {body, ~^body};
  assign ds_addr_in = cs_addr_in ^ 16'hA5A5;
  assign read_load = cs_addr_in[0] | bad_ds;
  assign read_data_high_byte = {~^acc_in, acc_in};
  // bad_ds spoils the low byte parity on purpose
  assign read_data_low_byte = {(~^cs_addr_in[7:0]) ^ bad_ds, cs_addr_in[7:0]};
  always @(posedge clk) begin
    if (srst) begin
      cs_addr_in <= 16'h0100;
      acc_in <= 8'h00;
    end else if (cpu_run) begin
      cs_addr_in <= cs_addr_in + 16'h0001;
      acc_in <= acc_in + 8'h11;
    end
  end
endmodule // cpu_model

/* File: test/test_microprogram_debug_console.sv */
/* self-checking bench for the debug console with the processor model.
   assumes zero-wait apb and the register map of the console. */
`timescale 1ns/1ns
`include "debug_console_defines.vh"
module test_microprogram_debug_console;
  reg clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, bad_ds = 0, err;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rd;
  reg [15:0] tgt;
  reg [23:0] w;
  wire [31:0] prdata;
  wire pready, pslverr, cpu_run, read_load, trap_req;
  wire [23:0] cs_instr_in, instr_out, ind_instr;
  wire [15:0] cs_addr_in, ds_addr_in, trap_addr, ind_addr;
  wire [7:0] acc_in, ind_acc;
  wire [8:0] rdh, rdl;
  integer n_errors = 0, total_checks = 0, seed = 94696, i, k, n;
  microprogram_debug_console i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_instr_in(cs_instr_in), .cs_addr_in(cs_addr_in),
    .ds_addr_in(ds_addr_in), .acc_in(acc_in), .read_load(read_load),
    .read_data_high_byte(rdh), .read_data_low_byte(rdl), .cpu_run(cpu_run),
    .instr_out(instr_out), .trap_req(trap_req), .trap_addr(trap_addr),
    .ind_instr(ind_instr), .ind_addr(ind_addr), .ind_acc(ind_acc));
  cpu_model i_cpu (.clk(clk), .srst(srst), .cpu_run(cpu_run), .bad_ds(bad_ds),
    .cs_addr_in(cs_addr_in), .acc_in(acc_in), .ds_addr_in(ds_addr_in),
    .cs_instr_in(cs_instr_in), .read_load(read_load), .read_data_high_byte(rdh),
    .read_data_low_byte(rdl));
  initial forever #10 clk = ~clk;
  // whole run needs about 500 cycles
  initial begin
    #200000;
    n_errors += 1;
    end_of_test;
  end
  task end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks += 1;
    if (g !== e) begin
      n_errors += 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input [7:0] a, input wr, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task runs(input integer c);
    n = 0;
    repeat (c) begin
      @(negedge clk);
      if (cpu_run === 1'b1) n += 1;
    end
  endtask
  // valid: exactly one group odd, or all three
  function perr(input [23:0] x);
    reg [2:0] g;
    g = {^x[23:16], ^x[15:8], ^x[7:0]};
    perr = !(g == 3'b001 || g == 3'b010 || g == 3'b100 || g == 3'b111);
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      apb(8'(i * 4), 0, 0);
      chk("reset value", i == 0 ? 8 : 0, rd);
      chk("slverr", i == 6, err);
    end
    apb(8'h00, 1, 0);
    for (i = 0; i < 3; i++) begin
      tgt = cs_addr_in;
      apb(8'h00, 1, 32'h100);
      runs(6);
      chk("step cycles", 1, n);
      chk("step address", tgt + 16'h1, cs_addr_in);
      chk("step acc lights", acc_in, ind_acc);
    end
    apb(8'h00, 1, 32'h108);
    runs(20);
    chk("run cycles", 20, n);
    apb(8'h00, 1, 32'h208);
    runs(4);
    chk("stopped", 0, n);
    for (k = 0; k < 2; k++) begin
      tgt = cs_addr_in + 16'd4 + 16'($random(seed) & 15);
      apb(8'h08, 1, k ? tgt : tgt ^ 16'hA5A5);
      apb(8'h00, 1, 32'h10C | (k << 1));
      i = 0;
      do begin @(negedge clk); i++; end while (cpu_run === 1'b1 && i < 40);
      chk("halt address", tgt, cs_addr_in);
      apb(8'h0C, 0, 0);
      chk("halt flag", 4, rd & 4);
      apb(8'h00, 1, 32'h10C | (k << 1));
      runs(16);
      chk("resume", 16, n);
      apb(8'h00, 1, 32'h208);
    end
    for (i = 0; i < 17; i++) begin
      w = i < 16 ? 24'h5C0000 | (24'h1 << (i + 2)) : 24'($random(seed));
      apb(8'h04, 1, w);
      apb(8'h00, 1, 1);
      repeat (3) @(negedge clk);
      chk("issued word", w, instr_out);
      chk("instr lights", w, ind_instr);
      if (i < 16) chk("branch lights", i < 6 ? 16'h400 << i : 16'h1 << (i - 6), ind_addr);
    end
    for (i = 0; i < 8; i++) begin
      w = i == 0 ? 24'h000000 : i == 1 ? 24'h010101 : 24'($random(seed));
      apb(8'h04, 1, w);
      apb(8'h0C, 1, 3);
      apb(8'h00, 1, 32'h101);
      runs(0);
      repeat (4) begin @(negedge clk); if (trap_req === 1'b1) n += 1; end
      chk("store trap", perr(w), n);
      if (perr(w)) chk("store vector", `TRAP_CS_PERR, trap_addr);
      apb(8'h0C, 0, 0);
      chk("store sticky", perr(w), rd & 1);
    end
    apb(8'h00, 1, 0);
    bad_ds <= 1'b1;
    apb(8'h0C, 1, 3);
    apb(8'h00, 1, 32'h100);
    repeat (4) @(negedge clk);
    chk("read vector", `TRAP_DS_PERR, trap_addr);
    apb(8'h0C, 0, 0);
    chk("read sticky", 2, rd & 3);
    end_of_test;
  end
endmodule // test_microprogram_debug_console
